// ===== clk_div_taps.v
// free-running divider of the system clock with one tick per tap
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/10ps

module clk_div_taps #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  // divider state
  output reg  [W-1:0] cnt_q,
  output reg  [W-1:0] tick_q
);

  wire [W-1:0] cnt_d;
  wire [W-1:0] tick_d;

  assign cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};

  // tap k pulses once every 2^(k+1) system clocks
  genvar k;
  generate
    for (k = 0; k < W; k = k + 1) begin : g_tap
      assign tick_d[k] = &cnt_q[k:0];
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= {W{1'b0}};
      tick_q <= {W{1'b0}};
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule // clk_div_taps

// ===== rtc_clock_source_select.v
// clock source selection of the real-time clock, its free-running
// counter mode, clock output pin and an axi4-lite register slave
// assumes one system clock; subclock, standby and init pins are asynchronous
`timescale 1ns/10ps
`include "rtc_csel_map.vh"

module rtc_clock_source_select #(
  parameter ADDR_W   = 8,
  parameter CNT_W    = 8,
  parameter SEC_DIV  = `SUB_CLK_HZ
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              rst_n,
  // device pins
  input  wire              sub_clk_pin,
  input  wire              hw_standby_input_n,
  input  wire              hard_init_input_n,
  output reg               timer_clock_out_pin,
  // clock output enable from the usb control register
  input  wire              timer_clock_out_enable,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // interrupt
  output reg               irq
);

  // decoding shared by the counter, the write path and the read path
  function is_calendar;
    input [3:0] code;
    begin
      is_calendar = (code == `SRC_CALENDAR);
    end
  endfunction

  function is_mapped;
    input [ADDR_W-1:0] a;
    begin
      is_mapped = (a[7:0] == `OFF_CSEL)       || (a[7:0] == `OFF_CTRL_ONE)   ||
                  (a[7:0] == `OFF_CTRL_TWO)   || (a[7:0] == `OFF_COUNT)      ||
                  (a[7:0] == `OFF_IRQ_STATUS) || (a[7:0] == `OFF_IRQ_ENABLE) ||
                  (a[7:0] == `OFF_IRQ_CLEAR);
    end
  endfunction

  // write strobe of one register offset
  function wr_hit;
    input              strobe;
    input [ADDR_W-1:0] a;
    input [7:0]        off;
    begin
      wr_hit = strobe && (a[7:0] == off);
    end
  endfunction

  localparam [7:0] CSEL_RESET   = `CSEL_RESET;
  localparam [7:0] CSEL_RW_MASK = `CSEL_RW_MASK;
  // prescaler end count, cut to the 15-bit prescaler width on purpose
  localparam [31:0] SEC_LAST_W  = SEC_DIV - 1;
  localparam [14:0] SEC_LAST    = SEC_LAST_W[14:0];

  // pin synchronisers
  reg              sub_s1_q;
  reg              sub_s2_q;
  reg              sub_s3_q;
  reg              hw_standby_input_s1_q;
  reg              hw_standby_input_s2_q;
  reg              init_s1_q;
  reg              init_s2_q;

  // registers
  reg  [7:0]       csel_q;
  reg              run_q;
  reg              overflow_irq_enable_q;
  reg  [CNT_W-1:0] count_q;
  reg  [14:0]      sec_cnt_q;
  reg  [`IRQ_W-1:0] irq_status_q;
  reg  [`IRQ_W-1:0] irq_enable_q;

  // bus holding state
  reg              aw_full_q;
  reg              w_full_q;
  reg  [ADDR_W-1:0] awaddr_q;
  reg  [31:0]      wdata_q;
  reg  [3:0]       wstrb_q;

  // divider taps
  wire [7:0]       div_cnt;
  wire [7:0]       div_tick;

  wire             sub_edge;
  wire             hold_init;
  wire [3:0]       src_code;
  wire [1:0]       out_code;
  wire             calendar;
  wire             src_tick;
  wire             count_step;
  wire             overflow;
  wire             sec_tick;
  wire             do_write;
  wire             wr_lane0;
  wire [`IRQ_W-1:0] irq_set;
  wire [`IRQ_W-1:0] irq_clr;
  reg              clk_out_d;
  reg  [31:0]      rdata_d;

  clk_div_taps #(
    .W       (8)
  ) u_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cnt_q   (div_cnt),
    .tick_q  (div_tick)
  );

  // two flops per pin before any logic looks at it
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sub_s1_q  <= 1'b0;
      sub_s2_q  <= 1'b0;
      sub_s3_q  <= 1'b0;
      hw_standby_input_s1_q <= 1'b1;
      hw_standby_input_s2_q <= 1'b1;
      init_s1_q <= 1'b1;
      init_s2_q <= 1'b1;
    end else begin
      sub_s1_q  <= sub_clk_pin;
      sub_s2_q  <= sub_s1_q;
      sub_s3_q  <= sub_s2_q;
      hw_standby_input_s1_q <= hw_standby_input_n;
      hw_standby_input_s2_q <= hw_standby_input_s1_q;
      init_s1_q <= hard_init_input_n;
      init_s2_q <= init_s1_q;
    end
  end

  // rising subclock edge seen after the synchroniser
  assign sub_edge  = sub_s2_q & ~sub_s3_q;
  assign hold_init = ~hw_standby_input_s2_q | ~init_s2_q;

  // fields of the source select register
  assign src_code = csel_q[`CSEL_SRC_HI:`CSEL_SRC_LO];
  assign out_code = csel_q[`CSEL_OUT_HI:`CSEL_OUT_LO];
  assign calendar = is_calendar(src_code);

  // codes 0..7 count the system clock over 2^(code+1), the rest the subclock
  assign src_tick = src_code[3] ? sub_edge : div_tick[src_code[2:0]];

  // counter only runs outside calendar work and with the run bit set
  assign count_step = ~calendar & run_q & src_tick;
  assign overflow   = count_step & (&count_q);
  assign sec_tick   = calendar & sub_edge & (sec_cnt_q == SEC_LAST);

  // write path
  assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_lane0 = do_write & wstrb_q[0];

  // status events: bit0 counter overflow, bit1 calendar second
  assign irq_set = {sec_tick, overflow};
  assign irq_clr = wr_hit(wr_lane0, awaddr_q, `OFF_IRQ_CLEAR) ?
                   wdata_q[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= {ADDR_W{1'b0}};
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_full_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_full_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software registers
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      csel_q       <= CSEL_RESET;
      run_q        <= 1'b0;
      overflow_irq_enable_q       <= 1'b0;
      irq_enable_q <= {`IRQ_W{1'b0}};
    end else begin
      if (hold_init) begin
        csel_q <= CSEL_RESET;
      end else if (wr_hit(wr_lane0, awaddr_q, `OFF_CSEL)) begin
        csel_q <= wdata_q[7:0] & CSEL_RW_MASK;
      end
      if (wr_hit(wr_lane0, awaddr_q, `OFF_CTRL_ONE)) begin
        run_q <= wdata_q[`CTRL_ONE_RUN];
      end
      if (wr_hit(wr_lane0, awaddr_q, `OFF_CTRL_TWO)) begin
        overflow_irq_enable_q <= wdata_q[`CTRL_TWO_OVERFLOW_IRQ_ENABLE];
      end
      if (wr_hit(wr_lane0, awaddr_q, `OFF_IRQ_ENABLE)) begin
        irq_enable_q <= wdata_q[`IRQ_W-1:0];
      end
    end
  end

  // free-running counter and calendar second prescaler
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q   <= {CNT_W{1'b0}};
      sec_cnt_q <= 15'h0000;
    end else begin
      if (count_step) begin
        count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (!calendar) begin
        sec_cnt_q <= 15'h0000;
      end else if (sub_edge) begin
        sec_cnt_q <= (sec_cnt_q == SEC_LAST) ? 15'h0000 : sec_cnt_q + 15'h0001;
      end
    end
  end

  // sticky status, a new event wins over a clear in the same cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_q <= {`IRQ_W{1'b0}};
      irq          <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      // the interrupt line follows status by one clock
      irq          <= (irq_status_q[`IRQ_OVF] & irq_enable_q[`IRQ_OVF] & overflow_irq_enable_q) |
                      (irq_status_q[`IRQ_SEC] & irq_enable_q[`IRQ_SEC]);
    end
  end

  // clock output pin
  always @* begin
    case (out_code)
      2'h1:    clk_out_d = div_cnt[2];
      2'h2:    clk_out_d = div_cnt[3];
      2'h3:    clk_out_d = div_cnt[4];
      default: clk_out_d = 1'b0;
    endcase
  end

  // registered so a code change cannot glitch the pin
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_clock_out_pin <= 1'b0;
    end else begin
      timer_clock_out_pin <= timer_clock_out_enable & clk_out_d;
    end
  end

  // read data mux
  always @* begin
    rdata_d = 32'h00000000;
    case (s_axi_araddr[7:0])
      `OFF_CSEL:       rdata_d[7:0] = csel_q & CSEL_RW_MASK;
      `OFF_CTRL_ONE: begin
        rdata_d[`CTRL_ONE_RUN] = run_q;
        rdata_d[`CTRL_ONE_CAL] = calendar;
      end
      `OFF_CTRL_TWO:   rdata_d[`CTRL_TWO_OVERFLOW_IRQ_ENABLE] = overflow_irq_enable_q;
      `OFF_COUNT:      rdata_d[CNT_W-1:0] = count_q;
      `OFF_IRQ_STATUS: rdata_d[`IRQ_W-1:0] = irq_status_q;
      `OFF_IRQ_ENABLE: rdata_d[`IRQ_W-1:0] = irq_enable_q;
      default:         rdata_d = 32'h00000000;
    endcase
  end

  // read channel
  // data captured with the address, held until rready
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdata_d;
        s_axi_rresp   <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // rtc_clock_source_select

// ===== rtc_clock_source_select_bench.sv
// self-checking bench of the clock source select block through its bus
// assumes the register map header; second timer scaled to four edges
`timescale 1ns/10ps
`include "rtc_csel_map.vh"
module rtc_clock_source_select_bench;
  reg         clk_sys = 1'b0, rst_n = 1'b0, sub_clk_pin = 1'b0;
  reg         hw_standby_input_n = 1'b1, hard_init_input_n = 1'b1;
  reg         timer_clock_out_enable = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, timer_clock_out_pin, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer     err_total = 0, compares = 0, n, k, c1;
  reg  [31:0] rd_q;
  reg  [2:0]  sub_cnt = 3'h0;
  reg         prev;

  rtc_clock_source_select #(.SEC_DIV(4)) DUT (.clk_sys, .rst_n, .sub_clk_pin,
    .hw_standby_input_n, .hard_init_input_n, .timer_clock_out_pin,
    .timer_clock_out_enable, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq);

  always #4 clk_sys = ~clk_sys;
  // subclock far below a third of the system clock
  always @(posedge clk_sys) begin
    sub_cnt <= (sub_cnt == 3'h5) ? 3'h0 : sub_cnt + 3'h1;
    if (sub_cnt == 3'h5) sub_clk_pin <= ~sub_clk_pin;
  end

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge clk_sys);
      while (s_axi_awvalid || s_axi_wvalid || s_axi_bready) begin
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bready && s_axi_bvalid) begin
          s_axi_bready <= 1'b0;
          chk(s_axi_bresp, er);
        end
        @(posedge clk_sys);
      end
    end
  endtask

  task rd(input [7:0] a, input [31:0] m, input [31:0] e, input [1:0] er);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge clk_sys);
      while (s_axi_arvalid || s_axi_rready) begin
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rready && s_axi_rvalid) begin
          s_axi_rready <= 1'b0;
          rd_q = s_axi_rdata;
          chk(s_axi_rresp, er);
          chk(rd_q & m, e);
        end
        @(posedge clk_sys);
      end
    end
  endtask

  task rate(input [7:0] code, input [31:0] lo, input [31:0] hi);
    begin
      wr(`OFF_CSEL, {24'h000000, code}, `RESP_OKAY);
      rd(`OFF_COUNT, 32'hFFFFFF00, 32'h0, `RESP_OKAY);
      c1 = rd_q & 32'hFF;
      repeat (256) @(posedge clk_sys);
      rd(`OFF_COUNT, 32'hFFFFFF00, 32'h0, `RESP_OKAY);
      c1 = ((rd_q & 32'hFF) - c1) & 32'hFF;
      chk(c1 >= lo && c1 <= hi, 32'h1);
    end
  endtask

  task edges;
    begin
      n = 0;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      prev = timer_clock_out_pin;
      repeat (256) begin
        @(negedge clk_sys);
        if (timer_clock_out_pin && !prev) n = n + 1;
        prev = timer_clock_out_pin;
      end
    end
  endtask

  task final_report;
    begin
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total = err_total + 1;
    final_report;
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(`OFF_CSEL, 32'hFF, 32'h08, `RESP_OKAY);
    rd(`OFF_CTRL_ONE, 32'h02, 32'h02, `RESP_OKAY);
    wr(`OFF_CSEL, 32'hFF, `RESP_OKAY);
    rd(`OFF_CSEL, 32'hFFFFFFFF, 32'h6F, `RESP_OKAY);
    s_axi_wstrb <= 4'hE;
    wr(`OFF_CSEL, 32'h00, `RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`OFF_CSEL, 32'hFF, 32'h6F, `RESP_OKAY);
    $display("test reset and reserved done");
    for (k = 0; k < 2; k = k + 1) begin
      wr(`OFF_CSEL, 32'h65, `RESP_OKAY);
      rd(`OFF_CSEL, 32'hFF, 32'h65, `RESP_OKAY);
      if (k == 0) hw_standby_input_n <= 1'b0;
      else hard_init_input_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      wr(`OFF_CSEL, 32'h61, `RESP_OKAY);
      rd(`OFF_CSEL, 32'hFF, 32'h08, `RESP_OKAY);
      hw_standby_input_n <= 1'b1;
      hard_init_input_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rd(`OFF_CSEL, 32'hFF, 32'h08, `RESP_OKAY);
    end
    $display("test standby and init done");
    wr(`OFF_CSEL, 32'h01, `RESP_OKAY);
    wr(`OFF_IRQ_CLEAR, 32'h03, `RESP_OKAY);
    rd(`OFF_CTRL_ONE, 32'hFF, 32'h00, `RESP_OKAY);
    rd(`OFF_COUNT, 32'hFFFFFFFF, 32'h0, `RESP_OKAY);
    c1 = rd_q & 32'hFF;
    repeat (40) @(posedge clk_sys);
    rd(`OFF_COUNT, 32'hFF, c1, `RESP_OKAY);
    wr(`OFF_CTRL_ONE, 32'h01, `RESP_OKAY);
    repeat ((256 - c1) * 4 - 80) @(posedge clk_sys);
    rd(`OFF_IRQ_STATUS, 32'h1, 32'h0, `RESP_OKAY);
    repeat (200) @(posedge clk_sys);
    rd(`OFF_IRQ_STATUS, 32'h1, 32'h1, `RESP_OKAY);
    wr(`OFF_IRQ_ENABLE, 32'h01, `RESP_OKAY);
    wr(`OFF_CTRL_TWO, 32'h00, `RESP_OKAY);
    repeat (4) @(posedge clk_sys);
    chk(irq, 32'h0);
    wr(`OFF_CTRL_TWO, 32'h01, `RESP_OKAY);
    repeat (4) @(posedge clk_sys);
    chk(irq, 32'h1);
    for (k = 0; k < 5; k = k + 1) begin
      rate(k, (32'h100 >> (k + 1)) - 32'h1, (32'h100 >> (k + 1)) + 32'h2);
    end
    rate(8'h09, 32'h14, 32'h17);
    wr(`OFF_CTRL_ONE, 32'h00, `RESP_OKAY);
    rd(`OFF_COUNT, 32'hFFFFFF00, 32'h0, `RESP_OKAY);
    c1 = rd_q & 32'hFF;
    repeat (30) @(posedge clk_sys);
    rd(`OFF_COUNT, 32'hFF, c1, `RESP_OKAY);
    wr(`OFF_IRQ_CLEAR, 32'h01, `RESP_OKAY);
    repeat (4) @(posedge clk_sys);
    chk(irq, 32'h0);
    $display("test free run and overflow done");
    timer_clock_out_enable <= 1'b1;
    for (k = 0; k < 4; k = k + 1) begin
      wr(`OFF_CSEL, (k << 5) | 32'h08, `RESP_OKAY);
      edges;
      chk(n, (k == 0) ? 32'h0 : (32'h100 >> (k + 2)));
    end
    timer_clock_out_enable <= 1'b0;
    edges;
    chk(n, 32'h0);
    $display("test clock output done");
    wr(`OFF_IRQ_CLEAR, 32'h03, `RESP_OKAY);
    repeat (100) @(posedge clk_sys);
    rd(`OFF_IRQ_STATUS, 32'h2, 32'h2, `RESP_OKAY);
    rd(`OFF_CTRL_ONE, 32'h2, 32'h2, `RESP_OKAY);
    rd(8'h1C, 32'hFFFFFFFF, 32'h0, `RESP_SLVERR);
    wr(8'h20, 32'h01, `RESP_SLVERR);
    $display("test calendar and unmapped done");
    final_report;
  end
endmodule // rtc_clock_source_select_bench

// ===== rtc_csel_map.vh
// register offsets, field positions, reset values and counts of the rtc
// clock source selection block; included by its bare name
`ifndef RTC_CSEL_MAP_VH
`define RTC_CSEL_MAP_VH

// byte offsets on the register bus
`define OFF_CSEL        8'h00
`define OFF_CTRL_ONE    8'h04
`define OFF_CTRL_TWO    8'h08
`define OFF_COUNT       8'h0C
`define OFF_IRQ_STATUS  8'h10
`define OFF_IRQ_ENABLE  8'h14
`define OFF_IRQ_CLEAR   8'h18

// clock source select register layout
`define CSEL_RESET      8'h08
`define CSEL_RW_MASK    8'h6F
`define CSEL_OUT_HI     6
`define CSEL_OUT_LO     5
`define CSEL_SRC_HI     3
`define CSEL_SRC_LO     0
`define SRC_CALENDAR    4'h8
`define OUT_OFF         2'h0

// control register fields
`define CTRL_ONE_RUN    0
`define CTRL_ONE_CAL    1
`define CTRL_TWO_OVERFLOW_IRQ_ENABLE   0

// interrupt status bits
`define IRQ_OVF         0
`define IRQ_SEC         1
`define IRQ_W           2

// subclock edges per calendar second
`define SUB_CLK_HZ      32768

// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ===== rtc_csel_props.sv
// assertions on the bus and clock output ports of the source select block
// assumes the register map header; bound into every instance of the block
`timescale 1ns/10ps
`include "rtc_csel_map.vh"
module rtc_csel_props #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire              clk_sys,
  input wire              rst_n,
  // clock output
  input wire              timer_clock_out_enable,
  input wire              timer_clock_out_pin,
  // register bus
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire [1:0]        s_axi_bresp,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire [1:0]        s_axi_rresp,
  input wire              s_axi_rvalid,
  input wire              s_axi_rready
);
  reg [ADDR_W-1:0] rd_addr_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      rd_addr_q <= {ADDR_W{1'b0}};
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr_q <= s_axi_araddr;
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  reserved_zero_a: assert property (
    s_axi_rvalid && rd_addr_q == `OFF_CSEL |-> !s_axi_rdata[7] && !s_axi_rdata[4])
    else $error("reserved bit reads one");
  unmapped_err_a: assert property (s_axi_rvalid && rd_addr_q > `OFF_IRQ_CLEAR
    |-> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read");
  clk_out_off_a: assert property (!timer_clock_out_enable |=> !timer_clock_out_pin)
    else $error("clock output while disabled");
endmodule // rtc_csel_props

bind rtc_clock_source_select rtc_csel_props #(.ADDR_W(ADDR_W)) props (.clk_sys,
  .rst_n, .timer_clock_out_enable, .timer_clock_out_pin, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
